// ==== hw/eqf_pkg.sv ====
// Shared constants and types for the equalizer coefficient bank
package eqf_pkg;

  // Register index and bus widths
  localparam int IDX_W    = 12;
  localparam int REG_W    = 16;
  localparam int COEF_W   = 12;
  localparam int CENTER_W = 18;
  localparam int NREGS    = 6;
  localparam int CNT_W    = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_A_SIXTH   = 12'h423;
  localparam logic [IDX_W-1:0] IDX_A_SEVENTH = 12'h425;
  localparam logic [IDX_W-1:0] IDX_A_EIGHTH  = 12'h427;
  localparam logic [IDX_W-1:0] IDX_A_NINTH   = 12'h429;
  localparam logic [IDX_W-1:0] IDX_B_FIRST   = 12'h448;
  localparam logic [IDX_W-1:0] IDX_MODE      = 12'h460;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 12'h461;
  localparam logic [IDX_W-1:0] IDX_NONE      = 12'hFFF;

  // Slot order of the writable registers
  localparam int SLOT_A6   = 0;
  localparam int SLOT_A7   = 1;
  localparam int SLOT_A8   = 2;
  localparam int SLOT_A9   = 3;
  localparam int SLOT_B1   = 4;
  localparam int SLOT_MODE = 5;
  localparam int NCOEF     = 5;
  localparam logic [IDX_W-1:0] REG_IDX [NREGS] = '{
    IDX_A_SIXTH, IDX_A_SEVENTH, IDX_A_EIGHTH, IDX_A_NINTH, IDX_B_FIRST, IDX_MODE};

  // Field layout and reset values
  localparam int RESV_LSB      = 12;
  localparam int MODE_DUAL_BIT = 0;
  localparam int STAT_CNT_LSB  = 8;
  localparam logic [REG_W-1:0] REG_RST = 16'h0000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // One register write as seen in the bus data phase
  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] data;
  } eqf_wr_t;

  // Coefficients handed to the filter datapath, center-tap width
  typedef struct packed {
    logic signed [CENTER_W-1:0] a6;
    logic signed [CENTER_W-1:0] a7;
    logic signed [CENTER_W-1:0] a8;
    logic signed [CENTER_W-1:0] a9;
    logic signed [CENTER_W-1:0] b1;
  } eqf_taps_t;

  // Sign-extend an outer coefficient to the center-tap width
  function automatic logic signed [CENTER_W-1:0] eqf_sext(input logic [COEF_W-1:0] c);
    eqf_sext = {{(CENTER_W-COEF_W){c[COEF_W-1]}}, c};
  endfunction : eqf_sext

endpackage : eqf_pkg

// ==== hw/eqf_coef_reg.sv ====
// One 16-bit read/write register with its own index decode
`timescale 1ns/1ps
module eqf_coef_reg #(
  parameter logic [eqf_pkg::IDX_W-1:0] IDX = 12'h000,
  parameter logic [eqf_pkg::REG_W-1:0] RST = 16'h0000
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  eqf_pkg::eqf_wr_t                  wr,
  output logic      [eqf_pkg::REG_W-1:0]    q
);
  import eqf_pkg::*;

  // All sixteen bits stored, reserved bits included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RST;
    end else if (wr.en && (wr.idx == IDX)) begin
      q <= wr.data;
    end
  end

endmodule : eqf_coef_reg

// ==== hw/eqf_ahb_slave.sv ====
// AHB-Lite slave front end: zero wait states, word writes only
`timescale 1ns/1ps
module eqf_ahb_slave (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic                        hready,
  input  wire logic [31:0]                 hwdata,
  input  wire logic [eqf_pkg::REG_W-1:0]   rd_val,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic      [31:0]                 hrdata,
  output logic      [eqf_pkg::IDX_W-1:0]   rd_idx,
  output eqf_pkg::eqf_wr_t                 wr
);
  import eqf_pkg::*;

  logic             addr_ok;
  logic             wr_pend;
  logic [IDX_W-1:0] wr_idx_q;
  logic             fwd;

  // Address phase accepted on NONSEQ or SEQ with the bus ready
  assign addr_ok = hsel && hready && htrans[1];
  // Out-of-range or unaligned addresses decode to no register
  assign rd_idx  = (haddr[31:14] == 18'h00000 && haddr[1:0] == 2'b00) ?
                   haddr[13:2] : IDX_NONE;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Write address held for the data phase; non-word sizes dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      wr_idx_q <= IDX_NONE;
    end else begin
      wr_pend  <= addr_ok && hwrite && (hsize == HSIZE_WORD);
      wr_idx_q <= rd_idx;
    end
  end

  assign wr.en   = wr_pend;
  assign wr.idx  = wr_idx_q;
  assign wr.data = hwdata[REG_W-1:0];

  // Read behind a write to the same stored word sees the new data;
  // unmapped and read-only words never forward, so they keep reading as before
  always_comb begin
    fwd = 1'b0;
    for (int i = 0; i < NREGS; i++) begin
      if (wr_pend && (wr_idx_q == rd_idx) && (rd_idx == REG_IDX[i])) begin
        fwd = 1'b1;
      end
    end
  end

  // Read data registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= {16'h0000, fwd ? hwdata[REG_W-1:0] : rd_val};
    end
  end

endmodule : eqf_ahb_slave

// ==== hw/eqf_coef_bank.sv ====
// Upper channel A and first channel B equalizer coefficients on AHB-Lite
// Overview of operation
// - Outer coefficient is signed 12 bits low; bits 15:12 reserved, writable, zero
// - Index 0x423 feeds tap six of channel A or single filter; resets zero
// - Index 0x425 feeds tap seven of channel A or single filter
// - Index 0x427 feeds tap eight of channel A or single filter
// - Index 0x429 feeds tap nine, the last, of channel A or single
// - Index 0x448 is a separate 16-bit channel B register, reset zero
// - Center tap is 18-bit signed, wider than the 12-bit outer taps
// - Index 0x448 feeds the first channel B tap in dual-channel mode
`timescale 1ns/1ps
module eqf_coef_bank (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic                        hready,
  input  wire logic [31:0]                 hwdata,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic      [31:0]                 hrdata,
  output eqf_pkg::eqf_taps_t               taps,
  output logic                             dual_mode,
  output logic                             coef_upd
);
  import eqf_pkg::*;

  // Bus side
  logic [IDX_W-1:0] rd_idx;
  logic [REG_W-1:0] rd_val;
  eqf_wr_t          wr;

  // Register contents and decode
  logic [REG_W-1:0] regs [NREGS];
  logic [NREGS-1:0] hit;
  logic             coef_hit;
  logic [CNT_W-1:0] wr_count;
  logic [REG_W-1:0] status;
  logic             upd_d1;

  // Coefficient fields as named wires
  logic [COEF_W-1:0] coef_a_sixth;
  logic [COEF_W-1:0] coef_a_seventh;
  logic [COEF_W-1:0] coef_a_eighth;
  logic [COEF_W-1:0] coef_a_ninth;
  logic [COEF_W-1:0] coef_b_first;

  // Helper history for checks
  logic [REG_W-1:0] wr_d1;
  logic [REG_W-1:0] wr_d2;

  // Bus front end
  eqf_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .rd_val    (rd_val),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_idx    (rd_idx),
    .wr        (wr)
  );

  // Coefficient and mode registers, all resetting to zero
  for (genvar i = 0; i < NREGS; i++) begin : g_reg
    eqf_coef_reg #(
      .IDX (REG_IDX[i]),
      .RST (REG_RST)
    ) u_reg (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr      (wr),
      .q       (regs[i])
    );
    assign hit[i] = wr.en && (wr.idx == REG_IDX[i]);
  end

  // Fields of the coefficient registers
  assign coef_a_sixth   = regs[SLOT_A6][COEF_W-1:0];
  assign coef_a_seventh = regs[SLOT_A7][COEF_W-1:0];
  assign coef_a_eighth  = regs[SLOT_A8][COEF_W-1:0];
  assign coef_a_ninth   = regs[SLOT_A9][COEF_W-1:0];
  assign coef_b_first   = regs[SLOT_B1][COEF_W-1:0];
  assign dual_mode      = regs[SLOT_MODE][MODE_DUAL_BIT];
  assign coef_hit       = |hit[NCOEF-1:0];

  // Status word: coefficient write count and live mode
  assign status = {wr_count, 7'h00, dual_mode};

  // Read mux; reserved bits return what was written
  always_comb begin
    rd_val = 16'h0000;
    for (int i = 0; i < NREGS; i++) begin
      if (rd_idx == REG_IDX[i]) begin
        rd_val = regs[i];
      end
    end
    if (rd_idx == IDX_STATUS) begin
      rd_val = status;
    end
  end

  // Count of coefficient writes, wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_count <= '0;
    end else if (coef_hit) begin
      wr_count <= wr_count + 8'h01;
    end
  end

  // Coefficients to the datapath, widened to the center-tap format
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taps <= '0;
    end else begin
      taps.a6 <= eqf_sext(coef_a_sixth);
      taps.a7 <= eqf_sext(coef_a_seventh);
      taps.a8 <= eqf_sext(coef_a_eighth);
      taps.a9 <= eqf_sext(coef_a_ninth);
      // Channel B tap only live in dual-channel mode
      taps.b1 <= dual_mode ? eqf_sext(coef_b_first) : 18'sh00000;
    end
  end

  // Update pulse aligned with the new coefficient at the outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upd_d1   <= 1'b0;
      coef_upd <= 1'b0;
    end else begin
      upd_d1   <= coef_hit;
      coef_upd <= upd_d1;
    end
  end

  // Write data history for the checks below
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_d1 <= 16'h0000;
      wr_d2 <= 16'h0000;
    end else begin
      wr_d1 <= wr.data;
      wr_d2 <= wr_d1;
    end
  end

  // Checks, all on the bus clock
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Reserved bits stored as written
  a_reserved_kept: assert property (
    hit[SLOT_A6] |=> regs[SLOT_A6][15:RESV_LSB] == wr_d1[15:RESV_LSB]
  ) else $error("reserved bits of tap six not stored");

  // Tap six reaches the datapath two cycles after its data phase
  a_tap6_value: assert property (
    hit[SLOT_A6] ##1 !hit[SLOT_A6] |=> taps.a6 == eqf_sext(wr_d2[COEF_W-1:0])
  ) else $error("tap six output does not follow write");

  // Tap seven register takes the written word
  a_tap7_store: assert property (
    hit[SLOT_A7] |=> regs[SLOT_A7] == wr_d1
  ) else $error("tap seven register not written");

  // Tap eight holds when not addressed
  a_tap8_hold: assert property (
    !hit[SLOT_A8] |=> $stable(regs[SLOT_A8])
  ) else $error("tap eight changed without a write");

  // Tap nine low bits reach the datapath
  a_tap9_value: assert property (
    hit[SLOT_A9] ##1 !hit[SLOT_A9] |=> taps.a9[COEF_W-1:0] == wr_d2[COEF_W-1:0]
  ) else $error("tap nine output does not follow write");

  // Channel B register keeps all sixteen bits
  a_b_store: assert property (
    hit[SLOT_B1] |=> regs[SLOT_B1] == wr_d1
  ) else $error("channel B register not written");

  // Outer taps sign-extended into the center-tap width
  a_center_width: assert property (
    taps.a6[CENTER_W-1:COEF_W] == {6{taps.a6[COEF_W-1]}} &&
    taps.a7[CENTER_W-1:COEF_W] == {6{taps.a7[COEF_W-1]}} &&
    taps.a8[CENTER_W-1:COEF_W] == {6{taps.a8[COEF_W-1]}} &&
    taps.a9[CENTER_W-1:COEF_W] == {6{taps.a9[COEF_W-1]}} &&
    taps.b1[CENTER_W-1:COEF_W] == {6{taps.b1[COEF_W-1]}}
  ) else $error("outer tap not sign-extended");

  // Dual mode passes the channel B coefficient
  a_b_dual: assert property (
    dual_mode |=> taps.b1[COEF_W-1:0] == $past(coef_b_first)
  ) else $error("channel B tap missing in dual mode");

  // Single mode silences channel B whatever its register holds
  a_single_zero: assert property (
    !dual_mode |=> taps.b1 == 18'sh00000
  ) else $error("channel B tap live in single mode");

  // Update pulse follows a coefficient write by two cycles
  a_upd_pulse: assert property (
    coef_hit |-> ##2 coef_upd
  ) else $error("coefficient update pulse missing");

  // Bus never stalls or errors
  a_bus_okay: assert property (
    hreadyout && !hresp
  ) else $error("bus answer not ready and okay");

  // Unmapped reads return zero
  a_unmapped_zero: assert property (
    hsel && hready && htrans[1] && !hwrite && rd_idx == IDX_NONE
    |=> hrdata == 32'h00000000
  ) else $error("unmapped read not zero");

  // Tap six holds when not addressed
  a_tap6_hold: assert property (
    !hit[SLOT_A6] |=> $stable(regs[SLOT_A6])
  ) else $error("tap six changed without a write");

  // Tap seven reaches the datapath two cycles after its data phase
  a_tap7_value: assert property (
    hit[SLOT_A7] ##1 !hit[SLOT_A7] |=> taps.a7 == eqf_sext(wr_d2[COEF_W-1:0])
  ) else $error("tap seven output does not follow write");

  // Tap seven holds when not addressed
  a_tap7_hold: assert property (
    !hit[SLOT_A7] |=> $stable(regs[SLOT_A7])
  ) else $error("tap seven changed without a write");

  // Tap eight reaches the datapath two cycles after its data phase
  a_tap8_value: assert property (
    hit[SLOT_A8] ##1 !hit[SLOT_A8] |=> taps.a8 == eqf_sext(wr_d2[COEF_W-1:0])
  ) else $error("tap eight output does not follow write");

  // Tap eight register takes the written word
  a_tap8_store: assert property (
    hit[SLOT_A8] |=> regs[SLOT_A8] == wr_d1
  ) else $error("tap eight register not written");

  // Tap nine holds when not addressed
  a_tap9_hold: assert property (
    !hit[SLOT_A9] |=> $stable(regs[SLOT_A9])
  ) else $error("tap nine changed without a write");

  // Tap nine register takes the written word
  a_tap9_store: assert property (
    hit[SLOT_A9] |=> regs[SLOT_A9] == wr_d1
  ) else $error("tap nine register not written");

  // Channel B reserved bits stored as written
  a_b_reserved: assert property (
    hit[SLOT_B1] |=> regs[SLOT_B1][15:RESV_LSB] == wr_d1[15:RESV_LSB]
  ) else $error("reserved bits of channel B not stored");

  // Channel B register holds when not addressed
  a_b_hold: assert property (
    !hit[SLOT_B1] |=> $stable(regs[SLOT_B1])
  ) else $error("channel B register changed without a write");

  // Channel B write reaches the datapath in dual mode
  a_b_value: assert property (
    hit[SLOT_B1] ##1 (!hit[SLOT_B1] && dual_mode) |=>
    taps.b1 == eqf_sext(wr_d2[COEF_W-1:0])
  ) else $error("channel B tap does not follow write");

  // Mode register takes the written mode bit
  a_mode_store: assert property (
    hit[SLOT_MODE] |=> dual_mode == wr_d1[MODE_DUAL_BIT]
  ) else $error("mode bit not written");

  // Write count steps once per coefficient write
  a_count_step: assert property (
    coef_hit |=> wr_count == $past(wr_count) + 8'h01
  ) else $error("write count did not step");

  // Write count holds without a coefficient write
  a_count_hold: assert property (
    !coef_hit |=> $stable(wr_count)
  ) else $error("write count changed without a write");

  // No update pulse without a coefficient write
  a_upd_only: assert property (
    !coef_hit |-> ##2 !coef_upd
  ) else $error("update pulse without a write");

  // Read data stands until the next read address phase
  a_hrdata_stands: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata)
  ) else $error("read data changed without a read");

  // Non-word writes never reach the registers
  a_size_drop: assert property (
    hsel && hready && htrans[1] && hwrite && hsize != HSIZE_WORD |=> !wr.en
  ) else $error("non-word write not dropped");

endmodule : eqf_coef_bank

// ==== tb/eqf_coef_bank_tb.sv ====
// Self-checking bench for the equalizer coefficient bank over AHB-Lite
`timescale 1ns/1ps
module eqf_coef_bank_tb;
  import eqf_pkg::*;

  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic               hready;
  logic [31:0]        hwdata;
  logic               hreadyout;
  logic               hresp;
  logic [31:0]        hrdata;
  eqf_taps_t          taps;
  logic               dual_mode;
  logic               coef_upd;
  int                 errors;
  int                 n_compared;
  int                 seed;
  int                 cycles;
  logic [REG_W-1:0]   exp_reg [NCOEF];
  logic [31:0]        rd;
  logic [2:0]         bus_size;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  eqf_coef_bank dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .taps      (taps),
    .dual_mode (dual_mode),
    .coef_upd  (coef_upd)
  );

  // Bus clock, 25 ns period
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      print_verdict();
    end
  end

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Byte address of a coefficient slot
  function automatic logic [31:0] addr_of(input int i);
    addr_of = {18'h0, REG_IDX[i], 2'b00};
  endfunction : addr_of

  // Outer coefficient widened to the center-tap width
  function automatic logic [31:0] widen(input logic [REG_W-1:0] v);
    widen = {14'h0, {6{v[11]}}, v[11:0]};
  endfunction : widen

  function automatic logic [31:0] tap_of(input int i);
    case (i)
      0: tap_of = {14'h0, taps.a6};
      1: tap_of = {14'h0, taps.a7};
      2: tap_of = {14'h0, taps.a8};
      3: tap_of = {14'h0, taps.a9};
      default: tap_of = {14'h0, taps.b1};
    endcase
  endfunction : tap_of

  // One AHB transfer; read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= bus_size;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus

  // Taps a6 to a9 against the expected register image, b1 too in dual mode and against zero in single mode
  task automatic check_taps();
    for (int i = 0; i < NCOEF; i++) begin
      if (i == SLOT_B1 && dual_mode !== 1'b1)
        check("tap b1 single", tap_of(i), 32'h0);
      else
        check("tap", tap_of(i), widen(exp_reg[i]));
    end
  endtask : check_taps

  // Main sequence
  initial begin
    logic [REG_W-1:0] v;
    int               n_wr;
    errors = 0;
    n_compared = 0;
    seed = 45;
    cycles = 0;
    n_wr = 0;
    bus_size = HSIZE_WORD;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check("taps at reset", {2'b0, taps[89:60]}, 32'h0);
    check("b1 at reset", tap_of(SLOT_B1), 32'h0);
    check("mode at reset", {31'h0, dual_mode}, 32'h0);
    // Reset values read back through the bus
    for (int i = 0; i < NCOEF; i++) begin
      exp_reg[i] = REG_RST;
      bus(1'b0, addr_of(i), 32'h0, rd);
      check("reset read", rd, 32'h0);
    end
    // Corner and random coefficients, single then dual mode
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 5; k++) begin
        for (int i = 0; i < NCOEF; i++) begin
          case (k)
            0: v = 16'h0800;
            1: v = 16'hF7FF;
            2: v = 16'hFFFF;
            default: v = 16'($random(seed));
          endcase
          bus(1'b1, addr_of(i), {16'($random(seed)), v}, rd);
          exp_reg[i] = v;
          n_wr = n_wr + 1;
          @(posedge hclk);
          #1;
          check("update pulse", {31'h0, coef_upd}, 32'h1);
          check_taps();
          check("tap written", tap_of(i), (i == SLOT_B1 && m == 0) ? 32'h0 : widen(v));
          @(posedge hclk);
          #1;
          check("pulse end", {31'h0, coef_upd}, 32'h0);
          bus(1'b0, addr_of(i), 32'h0, rd);
          check("read back", rd, {16'h0, v});
        end
      end
      // Enter dual mode; b1 appears with the same latency
      bus(1'b1, {18'h0, IDX_MODE, 2'b00}, 32'h1, rd);
      @(posedge hclk);
      #1;
      check("dual mode", {31'h0, dual_mode}, 32'h1);
      check("b1 dual", tap_of(SLOT_B1), widen(exp_reg[SLOT_B1]));
    end
    // Back to single mode: b1 hidden but still stored
    bus(1'b1, {18'h0, IDX_MODE, 2'b00}, 32'h0, rd);
    @(posedge hclk);
    #1;
    check_taps();
    bus(1'b0, addr_of(SLOT_B1), 32'h0, rd);
    check("b1 kept", rd, {16'h0, exp_reg[SLOT_B1]});
    // Byte-size write is dropped, tap six keeps its word
    bus_size = 3'h0;
    bus(1'b1, addr_of(SLOT_A6), 32'h0000ABCD, rd);
    bus_size = HSIZE_WORD;
    bus(1'b0, addr_of(SLOT_A6), 32'h0, rd);
    check("byte write dropped", rd, {16'h0, exp_reg[SLOT_A6]});
    // Unmapped place reads zero
    bus(1'b0, {18'h0, IDX_NONE, 2'b00}, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    check("response okay", {31'h0, hresp}, 32'h0);
    check("ready", {31'h0, hreadyout}, 32'h1);
    // Status counts coefficient writes and shows single mode; writes ignored
    bus(1'b0, {18'h0, IDX_STATUS, 2'b00}, 32'h0, rd);
    check("status", rd, {16'h0, n_wr[7:0], 7'h00, 1'b0});
    bus(1'b1, {18'h0, IDX_STATUS, 2'b00}, 32'h0000FFFF, rd);
    bus(1'b0, {18'h0, IDX_STATUS, 2'b00}, 32'h0, rd);
    check("status read only", rd, {16'h0, n_wr[7:0], 7'h00, 1'b0});
    // Reset in mid-run clears every register again
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, addr_of(SLOT_A6), 32'h0, rd);
    check("tap six after reset", rd, 32'h0);
    bus(1'b0, addr_of(SLOT_B1), 32'h0, rd);
    check("b1 after reset", rd, 32'h0);
    bus(1'b0, {18'h0, IDX_STATUS, 2'b00}, 32'h0, rd);
    check("status after reset", rd, 32'h0);
    check("tap nine after reset", tap_of(SLOT_A9), 32'h0);
    print_verdict();
  end

endmodule : eqf_coef_bank_tb
